// >>> design/blrc_pkg.sv
// constants and types of the block-level reset control
package blrc_pkg;
  localparam int unsigned AW = 16;
  localparam int unsigned DW = 32;
  localparam logic [AW-1:0] RST_CTL_OFS = 16'h01f8;
  localparam logic [AW-1:0] HOST_SEQ_OFS = 16'h0040;
  localparam int unsigned BIT_DIG = 0;
  localparam int unsigned BIT_PHYA = 1;
  localparam int unsigned BIT_PHYB = 2;
  localparam int unsigned BIT_CORE = 6;
  localparam int unsigned CTRL_W = 7;
  localparam logic [7:0] SEQ_B0 = 8'h52;
  localparam logic [7:0] SEQ_B1 = 8'h45;
  localparam logic [7:0] SEQ_B2 = 8'h53;
  localparam int unsigned NPORT = 3;
  localparam int unsigned FX_PORT_A = 0;
  localparam int unsigned FX_PORT_A_UP = 2;
  localparam int unsigned FX_PORT_B = 1;
  localparam int unsigned CLK_MHZ = 25;
  localparam int unsigned T_PHY_US = 102;
  localparam int unsigned T_DIG_US = 760;
  localparam int unsigned T_CORE_US = 1;
  localparam int unsigned T_SYS_MS = 80;
  localparam int unsigned TMR_W = 21;
  localparam logic [TMR_W-1:0] PHY_CYC = TMR_W'(T_PHY_US * CLK_MHZ);
  localparam logic [TMR_W-1:0] DIG_CYC = TMR_W'(T_DIG_US * CLK_MHZ);
  localparam logic [TMR_W-1:0] CORE_CYC = TMR_W'(T_CORE_US * CLK_MHZ);
  localparam logic [TMR_W-1:0] SYS_CYC = TMR_W'(T_SYS_MS * 1000 * CLK_MHZ);

  typedef struct packed {
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
    logic wr;
    logic rd;
  } blrc_bus_req_t;

  typedef enum logic [1:0] {
    BLRC_TWO_PORT,
    BLRC_THREE_DOWN,
    BLRC_THREE_UP
  } blrc_port_mode_t;

  typedef enum logic [1:0] {
    BLRC_KIND_FULL,
    BLRC_KIND_KEEP_NOT_AFFECTED_BY_SOFT_RESET,
    BLRC_KIND_NO_RELOAD
  } blrc_phy_kind_t;
endpackage : blrc_pkg

// >>> design/blrc_hold_timer.sv
// fixed-length reset hold timer with completion pulse
`timescale 1ns/1ps
module blrc_hold_timer #(
  parameter logic [blrc_pkg::TMR_W-1:0] HOLD = {{(blrc_pkg::TMR_W-1){1'b0}}, 1'b1}
) (
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  input wire logic start_in,
  output logic busy_out,
  output logic done_out
);
  import blrc_pkg::*;

  logic [TMR_W-1:0] cnt_q;

  // a start while busy is dropped, so a pending hold never restarts
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      busy_out <= 1'b0;
      done_out <= 1'b0;
      cnt_q <= '0;
    end else begin
      done_out <= 1'b0;
      if (!busy_out) begin
        if (start_in) begin
          busy_out <= 1'b1;
          cnt_q <= '0;
        end
      end else if (cnt_q == HOLD - 1'b1) begin
        busy_out <= 1'b0;
        done_out <= 1'b1;
      end else begin
        cnt_q <= cnt_q + 1'b1;
      end
    end
  end
endmodule : blrc_hold_timer

// >>> design/blrc_seq_detect.sv
// three-byte write sequence detector
`timescale 1ns/1ps
module blrc_seq_detect (
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  input wire logic clr_in,
  input wire logic wr_in,
  input wire logic [7:0] byte_in,
  output logic hit_out
);
  import blrc_pkg::*;

  typedef enum logic [1:0] {IDLE, GOT_0, GOT_1} blrc_seq_st_t;
  blrc_seq_st_t st_q;

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_q <= IDLE;
      hit_out <= 1'b0;
    end else begin
      hit_out <= 1'b0;
      if (clr_in) begin
        st_q <= IDLE;
      end else if (wr_in) begin
        // a wrong byte restarts, but may itself open a new match
        unique case (st_q)
          IDLE: st_q <= (byte_in == SEQ_B0) ? GOT_0 : IDLE;
          GOT_0: st_q <= (byte_in == SEQ_B1) ? GOT_1 :
                         (byte_in == SEQ_B0) ? GOT_0 : IDLE;
          GOT_1: begin
            hit_out <= (byte_in == SEQ_B2);
            st_q <= (byte_in == SEQ_B0) ? GOT_0 : IDLE;
          end
        endcase
      end
    end
  end
endmodule : blrc_seq_detect

// >>> design/blrc_top.sv
// block-level reset control: reset register, phy, core and system resets
`timescale 1ns/1ps
module blrc_top #(
  parameter logic [blrc_pkg::TMR_W-1:0] DIG_HOLD = blrc_pkg::DIG_CYC,
  parameter logic [blrc_pkg::TMR_W-1:0] SYS_HOLD = blrc_pkg::SYS_CYC
) (
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  input wire blrc_pkg::blrc_bus_req_t bus_in,
  output logic [blrc_pkg::DW-1:0] rdata_out,
  input wire logic master_seq_wr_in,
  input wire logic [7:0] master_seq_byte_in,
  input wire logic phy_a_soft_req_in,
  input wire logic phy_b_soft_req_in,
  input wire logic phy_a_pd_exit_in,
  input wire logic phy_b_pd_exit_in,
  input wire logic phy_a_fx_in,
  input wire logic phy_b_fx_in,
  input wire logic [blrc_pkg::NPORT-1:0] fx_err_in,
  input wire blrc_pkg::blrc_port_mode_t port_mode_in,
  input wire logic eeprom_done_in,
  input wire logic sys_rst_pin_in,
  output logic port_a_phy_reset_bit_out,
  output logic port_b_phy_reset_bit_out,
  output blrc_pkg::blrc_phy_kind_t phy_a_kind_out,
  output blrc_pkg::blrc_phy_kind_t phy_b_kind_out,
  output logic phy_a_soft_clr_out,
  output logic phy_b_soft_clr_out,
  output logic digital_rst_out,
  output logic core_rst_out,
  output logic chip_sys_rst_out,
  output logic host_if_disable_out,
  output logic eeprom_load_out,
  output logic strap_latch_out,
  output logic sys_rst_pin_out,
  output logic sys_rst_pin_oe_out
);
  import blrc_pkg::*;

  function automatic logic [DW-1:0] ctrl_word(
    input logic dig, input logic a, input logic b, input logic core
  );
    logic [DW-1:0] w;
    w = '0;
    w[BIT_DIG] = dig;
    w[BIT_PHYA] = a;
    w[BIT_PHYB] = b;
    w[BIT_CORE] = core;
    return w;
  endfunction : ctrl_word

  //////////////////////////////////////////////////////////////////////
  // reset release

  logic rs1_q;
  logic rst_l;

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rs1_q <= 1'b0;
      rst_l <= 1'b0;
    end else begin
      rs1_q <= 1'b1;
      rst_l <= rs1_q;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // register decode

  logic ctl_wr;
  logic dig_q;
  logic core_q;
  logic [1:0] phy_q;
  logic dig_set;
  logic core_set;
  logic [1:0] phy_set;

  assign ctl_wr = bus_in.wr && (bus_in.addr == RST_CTL_OFS);
  // writes while a bit is set are dropped
  assign dig_set = ctl_wr && bus_in.wdata[BIT_DIG] && !dig_q;
  assign core_set = ctl_wr && bus_in.wdata[BIT_CORE] && !core_q;
  assign phy_set[0] = ctl_wr && bus_in.wdata[BIT_PHYA] && !phy_q[0];
  assign phy_set[1] = ctl_wr && bus_in.wdata[BIT_PHYB] && !phy_q[1];

  //////////////////////////////////////////////////////////////////////
  // phy reset sources

  logic [1:0] fx_hit;
  logic [1:0] soft_req;
  logic [1:0] pd_req;
  logic [1:0] phy_start;
  logic [1:0] phy_busy;
  logic [1:0] phy_done;
  blrc_phy_kind_t kind_q [2];

  // the monitored port for phy a moves with the port arrangement
  assign fx_hit[0] = phy_a_fx_in && ((port_mode_in == BLRC_THREE_UP) ?
                     fx_err_in[FX_PORT_A_UP] : fx_err_in[FX_PORT_A]);
  assign fx_hit[1] = phy_b_fx_in && fx_err_in[FX_PORT_B];
  assign soft_req = {phy_b_soft_req_in, phy_a_soft_req_in};
  assign pd_req = {phy_b_pd_exit_in, phy_a_pd_exit_in};
  assign phy_start = phy_set | soft_req | pd_req | fx_hit;

  for (genvar i = 0; i < 2; i++) begin : g_phy
    blrc_hold_timer #(
      .HOLD(PHY_CYC)
    ) u_tmr (
      .core_clk_in(core_clk_in),
      .rst_n_in(rst_l),
      .start_in(phy_start[i]),
      .busy_out(phy_busy[i]),
      .done_out(phy_done[i])
    );

    // set wins over the completion clear
    always_ff @(posedge core_clk_in or negedge rst_l) begin
      if (!rst_l) begin
        phy_q[i] <= 1'b0;
      end else if (phy_start[i]) begin
        phy_q[i] <= 1'b1;
      end else if (phy_done[i]) begin
        phy_q[i] <= 1'b0;
      end
    end

    // a full reset outranks a register-keeping one
    always_ff @(posedge core_clk_in or negedge rst_l) begin
      if (!rst_l) begin
        kind_q[i] <= BLRC_KIND_FULL;
      end else if (phy_start[i] && !phy_busy[i]) begin
        if (phy_set[i] || fx_hit[i]) begin
          kind_q[i] <= BLRC_KIND_FULL;
        end else if (soft_req[i]) begin
          kind_q[i] <= BLRC_KIND_KEEP_NOT_AFFECTED_BY_SOFT_RESET;
        end else begin
          kind_q[i] <= BLRC_KIND_NO_RELOAD;
        end
      end
    end
  end

  // only the phy sees its own reset
  assign port_a_phy_reset_bit_out = phy_busy[0];
  assign port_b_phy_reset_bit_out = phy_busy[1];
  assign phy_a_soft_clr_out = phy_done[0];
  assign phy_b_soft_clr_out = phy_done[1];
  assign phy_a_kind_out = kind_q[0];
  assign phy_b_kind_out = kind_q[1];

  //////////////////////////////////////////////////////////////////////
  // digital and core resets

  logic dig_busy;
  logic dig_done;
  logic core_busy;
  logic core_done;
  logic core_rst_q;

  blrc_hold_timer #(
    .HOLD(DIG_HOLD)
  ) u_dig (
    .core_clk_in(core_clk_in),
    .rst_n_in(rst_l),
    .start_in(dig_set),
    .busy_out(dig_busy),
    .done_out(dig_done)
  );

  blrc_hold_timer #(
    .HOLD(CORE_CYC)
  ) u_core (
    .core_clk_in(core_clk_in),
    .rst_n_in(rst_l),
    .start_in(core_set),
    .busy_out(core_busy),
    .done_out(core_done)
  );

  // phy timers stay outside the digital reset domain
  assign digital_rst_out = dig_busy;

  always_ff @(posedge core_clk_in or negedge rst_l) begin
    if (!rst_l) begin
      dig_q <= 1'b0;
    end else if (dig_set) begin
      dig_q <= 1'b1;
    end else if (dig_done) begin
      dig_q <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_l) begin
    if (!rst_l) begin
      core_q <= 1'b0;
    end else if (core_set) begin
      core_q <= 1'b1;
    end else if (core_done) begin
      core_q <= 1'b0;
    end
  end

  // the digital reset also takes the slave core down
  always_ff @(posedge core_clk_in or negedge rst_l) begin
    if (!rst_l) begin
      core_rst_q <= 1'b1;
    end else begin
      core_rst_q <= core_busy || dig_busy;
    end
  end
  assign core_rst_out = core_rst_q;

  //////////////////////////////////////////////////////////////////////
  // eeprom load, straps and host access

  logic first_q;
  logic strap_q;
  logic ee_q;
  logic hid_q;

  always_ff @(posedge core_clk_in or negedge rst_l) begin
    if (!rst_l) begin
      first_q <= 1'b1;
      strap_q <= 1'b0;
      ee_q <= 1'b0;
    end else begin
      first_q <= 1'b0;
      // straps latch only once after the chip-level release
      strap_q <= first_q;
      ee_q <= first_q || dig_done || core_done;
    end
  end
  assign strap_latch_out = strap_q;
  assign eeprom_load_out = ee_q;

  always_ff @(posedge core_clk_in or negedge rst_l) begin
    if (!rst_l) begin
      hid_q <= 1'b1;
    end else if (dig_busy || core_busy || ee_q) begin
      hid_q <= 1'b1;
    end else if (eeprom_done_in) begin
      hid_q <= 1'b0;
    end
  end
  assign host_if_disable_out = hid_q;

  //////////////////////////////////////////////////////////////////////
  // register read

  logic [DW-1:0] rd_q;

  // reads have no side effect, so any byte subset may be read alone
  always_ff @(posedge core_clk_in or negedge rst_l) begin
    if (!rst_l) begin
      rd_q <= '0;
    end else if (bus_in.rd && bus_in.addr == RST_CTL_OFS) begin
      rd_q <= ctrl_word(dig_q, phy_q[0], phy_q[1], core_q);
    end else begin
      rd_q <= '0;
    end
  end
  assign rdata_out = rd_q;

  //////////////////////////////////////////////////////////////////////
  // system reset

  logic host_hit;
  logic mst_hit;
  logic sys_busy;
  logic sys_done;
  logic p1_q;
  logic p2_q;
  logic p3_q;
  logic pin_hi_q;
  logic tail_q;
  logic csr_q;

  // the detectors live in the slave core, so both core and digital resets clear them
  blrc_seq_detect u_host_seq (
    .core_clk_in(core_clk_in),
    .rst_n_in(rst_l),
    .clr_in(core_busy || dig_busy),
    .wr_in(bus_in.wr && bus_in.addr == HOST_SEQ_OFS),
    .byte_in(bus_in.wdata[7:0]),
    .hit_out(host_hit)
  );

  blrc_seq_detect u_mst_seq (
    .core_clk_in(core_clk_in),
    .rst_n_in(rst_l),
    .clr_in(core_busy || dig_busy),
    .wr_in(master_seq_wr_in),
    .byte_in(master_seq_byte_in),
    .hit_out(mst_hit)
  );

  blrc_hold_timer #(
    .HOLD(SYS_HOLD)
  ) u_sys (
    .core_clk_in(core_clk_in),
    .rst_n_in(rst_l),
    .start_in(host_hit || mst_hit),
    .busy_out(sys_busy),
    .done_out(sys_done)
  );

  assign sys_rst_pin_out = 1'b0;
  assign sys_rst_pin_oe_out = sys_busy;

  always_ff @(posedge core_clk_in or negedge rst_l) begin
    if (!rst_l) begin
      p1_q <= 1'b1;
      p2_q <= 1'b1;
      p3_q <= 1'b1;
      pin_hi_q <= 1'b1;
    end else begin
      p1_q <= sys_rst_pin_in;
      p2_q <= p1_q;
      p3_q <= p2_q;
      if (p2_q == p3_q) begin
        pin_hi_q <= p3_q;
      end
    end
  end

  // another party may keep the wired-or line low past our drive
  always_ff @(posedge core_clk_in or negedge rst_l) begin
    if (!rst_l) begin
      tail_q <= 1'b0;
      csr_q <= 1'b0;
    end else begin
      if (sys_done) begin
        tail_q <= 1'b1;
      end else if (pin_hi_q) begin
        tail_q <= 1'b0;
      end
      csr_q <= sys_busy || tail_q;
    end
  end
  assign chip_sys_rst_out = csr_q;

  //////////////////////////////////////////////////////////////////////
  // checks

  logic [TMR_W-1:0] a_cnt;
  logic [TMR_W-1:0] d_cnt;
  logic [TMR_W-1:0] s_cnt;

  always_ff @(posedge core_clk_in or negedge rst_l) begin
    if (!rst_l) begin
      a_cnt <= '0;
      d_cnt <= '0;
      s_cnt <= '0;
    end else begin
      a_cnt <= phy_busy[0] ? a_cnt + 1'b1 : '0;
      d_cnt <= dig_busy ? d_cnt + 1'b1 : '0;
      s_cnt <= sys_busy ? s_cnt + 1'b1 : '0;
    end
  end

  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!rst_l);

  AST_PHYA_HOLD: assert property (
    $fell(phy_busy[0]) |-> a_cnt == PHY_CYC)
    else $error("phy a hold length wrong");
  AST_PHYA_CLR: assert property (
    $fell(phy_busy[0]) && !phy_start[0] |=> !phy_q[0])
    else $error("phy a bit not cleared at release");
  AST_PHYB_SRC: assert property (
    phy_set[1] && !phy_busy[1] |=> port_b_phy_reset_bit_out && phy_q[1])
    else $error("phy b reset not started");
  AST_DIG_HOLD: assert property (
    $fell(dig_busy) |-> d_cnt == DIG_HOLD ##1 eeprom_load_out && !dig_q)
    else $error("digital reset length or reload wrong");
  AST_WR_IGN: assert property (
    core_q && !core_done |=> core_q)
    else $error("core bit cleared early");
  AST_RSVD: assert property (
    rdata_out[DW-1:CTRL_W] == '0 && rdata_out[5:3] == '0)
    else $error("reserved bits not zero");
  AST_RD_LAT: assert property (
    bus_in.rd && bus_in.addr == RST_CTL_OFS
    |=> rdata_out[BIT_PHYA] == $past(phy_q[0]))
    else $error("read data wrong");
  AST_SEQ_PIN: assert property (
    (host_hit || mst_hit) && !sys_busy |=> sys_rst_pin_oe_out)
    else $error("sequence did not drive pin");
  AST_PIN_80: assert property (
    $fell(sys_rst_pin_oe_out) |-> s_cnt >= SYS_HOLD)
    else $error("reset pin released early");
  AST_HOST_DIS: assert property (
    core_busy |=> host_if_disable_out [*2])
    else $error("host interface enabled during core reset");
  AST_FX_A: assert property (
    fx_hit[0] && !phy_busy[0] |=> port_a_phy_reset_bit_out && phy_a_kind_out == BLRC_KIND_FULL)
    else $error("fx error did not reset phy a");

  COV_PHY_SOFT: cover property (
    phy_a_soft_req_in && !phy_busy[0] ##1 phy_a_kind_out == BLRC_KIND_KEEP_NOT_AFFECTED_BY_SOFT_RESET);
  COV_DIG: cover property ($fell(dig_busy));
  COV_SYS: cover property (host_hit ##1 sys_rst_pin_oe_out);
  COV_CORE: cover property (core_done ##1 eeprom_load_out);
endmodule : blrc_top

// >>> tb/blrc_far_model.sv
// far-side model: eeprom loader and the wired system reset pin
`timescale 1ns/1ps
module blrc_far_model #(
  parameter int LOAD_CYC = 30
) (
  input wire logic core_clk_in,
  input wire logic eeprom_load_in,
  output logic eeprom_done_out,
  input wire logic pin_oe_in,
  input wire logic pin_drv_in,
  output logic pin_level_out
);
  int cnt = 0;
  // pin has a pull-up, so a released pin reads high
  assign pin_level_out = pin_oe_in ? pin_drv_in : 1'b1;
  // load takes a while, so host stays locked out long enough to be seen
  always @(posedge core_clk_in) begin
    eeprom_done_out <= (!eeprom_load_in && cnt == 1);
    if (eeprom_load_in) begin
      cnt <= LOAD_CYC;
    end else if (cnt != 0) begin
      cnt <= cnt - 1;
    end
  end
endmodule : blrc_far_model

// >>> tb/test_blrc_top.sv
// self-checking bench of the block-level reset control
`timescale 1ns/1ps
module test_blrc_top;
  import blrc_pkg::*;
  localparam int DIGH = 40;
  localparam int SYSH = 50;
  localparam int PHYL = int'(PHY_CYC);
  localparam int COREL = int'(CORE_CYC);
  logic core_clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  blrc_bus_req_t bus_in = '0;
  logic [DW-1:0] rdata_out;
  logic mwr = 1'b0;
  logic [7:0] mbyte = 8'h00;
  logic [3:0] pq = 4'h0;
  logic fxa = 1'b0;
  logic fxb = 1'b0;
  logic [NPORT-1:0] fx_err = '0;
  blrc_port_mode_t pmode = BLRC_TWO_PORT;
  logic ee_done, pin_lvl, pa, pb, sca, scb, dig, core, csys, hdis, eld, strap, pout, poe;
  blrc_phy_kind_t ka, kb;
  int err_total = 0;
  int check_count = 0;
  logic [31:0] seed = 32'h9d5db0be;
  logic [31:0] q_rd[$];
  logic [31:0] q_len[5][$];
  logic [31:0] e, g;
  int cnt[5];
  logic [1:0] kd[5] = '{default: 2'h0};
  logic rd_seen = 1'b0;
  int n_load = 0;
  int n_strap = 0;
  logic [4:0] mon;
  assign mon = {poe, core, dig, pb, pa};
  always #20 core_clk_in = ~core_clk_in;
  blrc_top #(.DIG_HOLD(TMR_W'(DIGH)), .SYS_HOLD(TMR_W'(SYSH))) dut_u (
    .core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .bus_in(bus_in), .rdata_out(rdata_out),
    .master_seq_wr_in(mwr), .master_seq_byte_in(mbyte),
    .phy_a_soft_req_in(pq[0]), .phy_b_soft_req_in(pq[1]),
    .phy_a_pd_exit_in(pq[2]), .phy_b_pd_exit_in(pq[3]),
    .phy_a_fx_in(fxa), .phy_b_fx_in(fxb), .fx_err_in(fx_err), .port_mode_in(pmode),
    .eeprom_done_in(ee_done), .sys_rst_pin_in(pin_lvl),
    .port_a_phy_reset_bit_out(pa), .port_b_phy_reset_bit_out(pb), .phy_a_kind_out(ka), .phy_b_kind_out(kb),
    .phy_a_soft_clr_out(sca), .phy_b_soft_clr_out(scb), .digital_rst_out(dig),
    .core_rst_out(core), .chip_sys_rst_out(csys), .host_if_disable_out(hdis),
    .eeprom_load_out(eld), .strap_latch_out(strap), .sys_rst_pin_out(pout),
    .sys_rst_pin_oe_out(poe)
  );
  blrc_far_model far_u (
    .core_clk_in(core_clk_in), .eeprom_load_in(eld), .eeprom_done_out(ee_done),
    .pin_oe_in(poe), .pin_drv_in(pout), .pin_level_out(pin_lvl)
  );
  ////////////////////////////////////////////////////////////////////////////////
  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task wrap_up();
    $display("comparisons %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : wrap_up
  task wr(input logic [15:0] a, input logic [31:0] d);
    @(posedge core_clk_in);
    bus_in <= '{a, d, 1'b1, 1'b0};
    @(posedge core_clk_in);
    bus_in <= '0;
    repeat (2) @(posedge core_clk_in);
  endtask : wr
  task rd(input logic [15:0] a, input logic [31:0] x);
    q_rd.push_back(x);
    @(posedge core_clk_in);
    bus_in <= '{a, 32'h0, 1'b0, 1'b1};
    @(posedge core_clk_in);
    bus_in <= '0;
  endtask : rd
  task pulse(input logic [3:0] v);
    @(posedge core_clk_in);
    pq <= v;
    @(posedge core_clk_in);
    pq <= '0;
  endtask : pulse
  task fxp(input int p);
    @(posedge core_clk_in);
    fx_err <= NPORT'(1 << p);
    @(posedge core_clk_in);
    fx_err <= '0;
  endtask : fxp
  task mseq(input logic [7:0] b);
    @(posedge core_clk_in);
    mwr <= 1'b1;
    mbyte <= b;
    @(posedge core_clk_in);
    mwr <= 1'b0;
  endtask : mseq
  task xl(input int i, input logic [1:0] k, input int len);
    q_len[i].push_back({14'h0, k, len[15:0]});
  endtask : xl
  // bounded wait until every reset has dropped and the host side is back
  task wait_idle();
    int n;
    n = 0;
    repeat (3) @(posedge core_clk_in);
    // the system reset output must also fall once the wired pin reads high again
    while ((mon !== 5'h0 || hdis !== 1'b0 || csys !== 1'b0) && n < 5000) begin
      @(posedge core_clk_in);
      n++;
    end
    if (n >= 5000) chk({26'h0, csys, mon}, 32'h0);
    repeat (3) @(posedge core_clk_in);
  endtask : wait_idle
  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge core_clk_in) rd_seen <= bus_in.rd;
  // pulse lengths are matched to within one cycle, though each hold lasts exactly its HOLD count of cycles
  always @(negedge core_clk_in) begin
    if (rd_seen) chk(rdata_out, q_rd.pop_front());
    if (poe === 1'b1) chk({31'h0, pout}, 32'h0);
    if (poe === 1'b1 && cnt[4] != 0) chk({31'h0, csys}, 32'h1);
    for (int i = 0; i < 5; i++) begin
      if (mon[i] === 1'b1) begin
        if (cnt[i] == 0 && i < 2) kd[i] = (i == 0) ? ka : kb;
        cnt[i]++;
      end else if (cnt[i] != 0) begin
        e = (q_len[i].size() != 0) ? q_len[i].pop_front() : 32'hdead0000;
        g = {14'h0, kd[i], cnt[i][15:0]};
        if (g[15:0] + 16'h1 == e[15:0] || g[15:0] == e[15:0] + 16'h1) g[15:0] = e[15:0];
        if (e !== 32'hffffffff) chk(g, e);
        if (i < 2) chk({31'h0, (i == 0) ? sca : scb}, 32'h1);
        cnt[i] = 0;
        kd[i] = 2'h0;
      end
    end
    if (eld === 1'b1) n_load++;
    if (strap === 1'b1) n_strap++;
  end
  initial begin
    repeat (40000) @(posedge core_clk_in);
    err_total++;
    $display("watchdog expired");
    wrap_up();
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    q_len[3].push_back(32'hffffffff);
    repeat (20) @(posedge core_clk_in);
    rst_n_in <= 1'b1;
    wait_idle();
    rd(RST_CTL_OFS, 32'h0);
    rd(16'h0100, 32'h0);
    for (int i = 0; i < 4; i++) begin
      wr(RST_CTL_OFS, rnd() & 32'hffffffb8);
      rd(RST_CTL_OFS, 32'h0);
    end
    $display("test reset and reserved done");
    for (int k = 0; k < 2; k++) begin
      xl(k, BLRC_KIND_FULL, PHYL);
      wr(RST_CTL_OFS, 32'h2 << k);
      rd(RST_CTL_OFS, 32'h2 << k);
      wr(RST_CTL_OFS, 32'h2 << k);
      wait_idle();
      rd(RST_CTL_OFS, 32'h0);
    end
    for (int j = 0; j < 4; j++) begin
      xl(j % 2, (j < 2) ? BLRC_KIND_KEEP_NOT_AFFECTED_BY_SOFT_RESET : BLRC_KIND_NO_RELOAD, PHYL);
      pulse(4'h1 << j);
      rd(RST_CTL_OFS, 32'h2 << (j % 2));
      wait_idle();
    end
    $display("test phy resets done");
    fxa <= 1'b1;
    fxb <= 1'b1;
    for (int m = 0; m < 3; m++) begin
      pmode <= blrc_port_mode_t'(m[1:0]);
      xl(0, BLRC_KIND_FULL, PHYL);
      fxp((m == 2) ? FX_PORT_A_UP : FX_PORT_A);
      wait_idle();
    end
    xl(1, BLRC_KIND_FULL, PHYL);
    fxp(FX_PORT_B);
    wait_idle();
    fxa <= 1'b0;
    fxb <= 1'b0;
    pmode <= BLRC_TWO_PORT;
    fxp(FX_PORT_A);
    fxp(FX_PORT_B);
    wait_idle();
    $display("test link errors done");
    xl(3, 2'h0, COREL);
    wr(RST_CTL_OFS, 32'h40);
    rd(RST_CTL_OFS, 32'h40);
    wr(RST_CTL_OFS, 32'h40);
    chk({31'h0, hdis}, 32'h1);
    wait_idle();
    rd(RST_CTL_OFS, 32'h0);
    xl(2, 2'h0, DIGH);
    q_len[3].push_back(32'hffffffff);
    wr(RST_CTL_OFS, 32'h1);
    rd(RST_CTL_OFS, 32'h1);
    wait_idle();
    rd(RST_CTL_OFS, 32'h0);
    chk(n_load, 32'h3);
    chk(n_strap, 32'h1);
    $display("test core and digital done");
    mseq(SEQ_B0);
    mseq(8'(rnd()) | 8'h80);
    mseq(SEQ_B1);
    mseq(SEQ_B2);
    wait_idle();
    xl(4, 2'h0, SYSH);
    mseq(SEQ_B0);
    mseq(SEQ_B0);
    mseq(SEQ_B1);
    mseq(SEQ_B2);
    wait_idle();
    xl(4, 2'h0, SYSH);
    wr(HOST_SEQ_OFS, {24'h0, SEQ_B0});
    wr(HOST_SEQ_OFS, {24'h0, SEQ_B1});
    wr(HOST_SEQ_OFS, {24'h0, SEQ_B2});
    wait_idle();
    $display("test system reset sequences done");
    wrap_up();
  end
endmodule : test_blrc_top
